// File: bench/emt_ext_mem_if_asserts.sv
// property checker for the external memory interface sequencer
`default_nettype none
module emt_ext_mem_if_asserts (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       moveStart,
  input wire logic       moveWide,
  input wire logic       moveBusy,
  input wire logic       moveDone,
  input wire logic [7:0] extIfConfig,
  input wire logic [7:0] extIfTimingCtrl,
  input wire logic       addrHiOe,
  input wire logic       addrLoOe,
  input wire logic       dataOe,
  input wire logic       rdStrobeN,
  input wire logic       wrStrobeN,
  input wire logic       aleOut,
  input wire logic       ctrlOe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] busyCnt, hiCnt, loCnt, wrHi, expLen, aleN;
  logic       wideQ;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  always_comb aleN = 8'(extIfConfig[4:3]) + 8'h01;
  always_comb expLen = 8'h05 + 8'(extIfTimingCtrl[7:6]) + 8'(extIfTimingCtrl[5:2])
    + 8'(extIfTimingCtrl[1:0]) + (extIfConfig[2] ? 8'h00 : 8'h02 * aleN);
  always_ff @(posedge core_clk)
  begin
    busyCnt <= moveBusy ? busyCnt + 8'h01 : 8'h00;
    hiCnt <= aleOut ? hiCnt + 8'h01 : 8'h00;
    loCnt <= (aleOut || !ctrlOe) ? 8'h00 : loCnt + 8'h01;
    wrHi <= (wrStrobeN && dataOe) ? wrHi + 8'h01 : 8'h00;
    wideQ <= (moveStart && !moveBusy) ? moveWide : wideQ;
  end
  chk_timing_reset: assert property ($fell(sys_rst) |-> extIfTimingCtrl == 8'hFF)
    else $error("timing not at reset value");
  chk_idle_quiet: assert property (!moveBusy |-> !(ctrlOe || dataOe || addrHiOe || addrLoOe))
    else $error("pins driven while idle");
  chk_nonmux_latch: assert property (extIfConfig[2] |-> !aleOut)
    else $error("latch strobe in non-multiplexed mode");
  chk_latch_high: assert property ($fell(aleOut) |-> hiCnt == aleN)
    else $error("latch high length wrong");
  chk_latch_low: assert property ($fell(rdStrobeN && wrStrobeN) && !extIfConfig[2] |-> loCnt >= aleN)
    else $error("latch low phase too short");
  chk_move_length: assert property (moveDone |-> busyCnt == expLen)
    else $error("move length wrong");
  chk_write_hold: assert property ($fell(dataOe) |-> wrHi == 8'(extIfTimingCtrl[1:0]) + 8'h01)
    else $error("write data hold wrong");
  chk_upper_idle: assert property (ctrlOe && !wideQ && extIfConfig[1:0] != 2'b10 |-> !addrHiOe)
    else $error("upper address driven without bank select");
endmodule
`default_nettype wire

// File: bench/emt_sram_model.sv
// asynchronous byte memory on the far side of the interface
`default_nettype none
module emt_sram_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] addrLoOut,
  input  wire logic       addrLoOe,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  input  wire logic       rdStrobeN,
  input  wire logic       wrStrobeN,
  output var  logic [7:0] memDataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] la, tog;
  logic       wrQ;
  initial tog = 8'h55;
  always @(posedge core_clk)
  begin
    if (addrLoOe)
      la <= addrLoOut;
    wrQ <= wrStrobeN;
    tog <= ~tog;
    if (wrStrobeN && !wrQ && dataOe)
      mem[la] <= dataOut;
  end
  // bus not driven outside the read strobe
  always_comb memDataIn = !rdStrobeN ? mem[la] : tog;
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the external memory interface sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, sys_rst, cfgWe, cfgUpperPorts, timingWe, moveStart, moveWrite;
  logic        moveWide, moveBusy, moveDone, addrHiOe, addrLoOe, dataOe, rdStrobeN;
  logic        wrStrobeN, aleOut, ctrlOe, usingUpperPorts, sawAle, sawHi;
  logic [2:0]  cfgMode;
  logic [1:0]  cfgAle;
  logic [7:0]  timingCtrl, bankSelect, moveWData, memDataIn, moveRData, extIfConfig;
  logic [7:0]  extIfTimingCtrl, addrHiOut, addrLoOut, dataOut, hiVal;
  logic [15:0] moveAddr;
  int          failures, n_tests, busyLen;
  emt_ext_mem_if uut (.core_clk, .sys_rst, .cfgWe, .cfgMode, .cfgAle, .cfgUpperPorts,
    .timingWe, .timingCtrl, .bankSelect, .moveStart, .moveWrite, .moveWide, .moveAddr,
    .moveWData, .memDataIn, .moveBusy, .moveDone, .moveRData, .extIfConfig,
    .extIfTimingCtrl, .addrHiOut, .addrHiOe, .addrLoOut, .addrLoOe, .dataOut, .dataOe,
    .rdStrobeN, .wrStrobeN, .aleOut, .ctrlOe, .usingUpperPorts);
  emt_sram_model mem (.core_clk, .addrLoOut, .addrLoOe, .dataOut, .dataOe, .rdStrobeN,
    .wrStrobeN, .memDataIn);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (aleOut)
      sawAle <= 1'b1;
    if (addrHiOe)
      sawHi <= 1'b1;
    if (addrHiOe)
      hiVal <= addrHiOut;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic move(input logic wr, input logic wide, input logic [15:0] a,
                      input logic [7:0] d);
    int n;
    moveStart <= 1'b1;
    moveWrite <= wr;
    moveWide <= wide;
    moveAddr <= a;
    moveWData <= d;
    @(posedge core_clk);
    moveStart <= 1'b0;
    sawAle = 1'b0;
    sawHi = 1'b0;
    busyLen = 0;
    n = 0;
    while (moveDone !== 1'b1 && n < 300)
    begin
      @(posedge core_clk);
      n++;
      busyLen += (moveBusy === 1'b1);
    end
    if (n == 300)
    begin
      failures++;
      summarize();
    end
  endtask
  task automatic setcfg(input logic [2:0] m, input logic [1:0] a, input logic [7:0] t);
    cfgWe <= 1'b1;
    timingWe <= 1'b1;
    cfgMode <= m;
    cfgAle <= a;
    cfgUpperPorts <= m[0];
    timingCtrl <= t;
    bankSelect <= {5'h15, m};
    @(posedge core_clk);
    cfgWe <= 1'b0;
    timingWe <= 1'b0;
    @(posedge core_clk);
    check("config", {8'h00, extIfConfig}, {11'h000, a, m});
    check("timing", {8'h00, extIfTimingCtrl}, {8'h00, t});
    check("port group", {15'h0000, usingUpperPorts}, {15'h0000, m[0]});
  endtask
  task automatic t_modes;
    logic [2:0] m;
    for (int i = 1; i < 8; i++)
    begin
      m = 3'(i);
      setcfg(m, m[1:0], 8'h0C);
      move(1'b1, 1'b1, {8'h80 + 8'(i), 8'h10 + 8'(i)}, 8'hC0 + 8'(i));
      check("length", 16'(busyLen), 16'(8 + (m[2] ? 0 : 2 * (m[1:0] + 1))));
      check("latch seen", {15'h0000, sawAle}, {15'h0000, !m[2]});
      check("wide upper", {8'h00, hiVal}, 16'h0080 + 16'(i));
      move(1'b0, 1'b1, {8'h80 + 8'(i), 8'h10 + 8'(i)}, 8'h00);
      check("wide read", {8'h00, moveRData}, 16'h00C0 + 16'(i));
      move(1'b1, 1'b0, 16'h0020 + 16'(i), 8'h30 + 8'(i));
      move(1'b0, 1'b0, 16'h0020 + 16'(i), 8'h00);
      check("byte read", {8'h00, moveRData}, 16'h0030 + 16'(i));
      check("bank drive", {15'h0000, sawHi}, {15'h0000, m[1:0] == 2'b10});
      if (m[1:0] == 2'b10)
        check("bank value", {8'h00, hiVal}, {8'h00, 5'h15, m});
    end
  endtask
  task automatic t_timing;
    logic [7:0] tab [3] = '{8'h00, 8'hFF, 8'h6D};
    logic [7:0] t;
    for (int i = 0; i < 6; i++)
    begin
      t = tab[i / 2];
      setcfg(i[0] ? 3'h5 : 3'h2, 2'(i), t);
      move(1'b1, 1'b1, 16'h4400 + 16'(i), 8'hE0);
      check("length", 16'(busyLen), 16'(5 + t[7:6] + t[5:2] + t[1:0]
        + (i[0] ? 0 : 2 * (i % 4 + 1))));
    end
  endtask
  task automatic t_refuse;
    setcfg(3'h3, 2'h1, 8'h0C);
    fork
      move(1'b1, 1'b1, 16'h1234, 8'h5A);
      begin
        repeat (3) @(posedge core_clk);
        {cfgWe, timingWe, moveStart} <= 3'h7;
        cfgMode <= 3'h5;
        timingCtrl <= 8'h00;
        @(posedge core_clk);
        {cfgWe, timingWe, moveStart} <= 3'h0;
      end
    join
    check("length", 16'(busyLen), 16'h000C);
    check("config kept", {8'h00, extIfConfig, extIfTimingCtrl}, 16'h0B0C);
    repeat (2) @(posedge core_clk);
    check("no second move", {15'h0000, moveBusy}, 16'h0000);
  endtask
  initial
  begin
    {sys_rst, cfgWe, cfgUpperPorts, timingWe, moveStart, moveWrite, moveWide} = 7'h40;
    {cfgMode, cfgAle, timingCtrl, bankSelect, moveWData, moveAddr} = 45'h0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    check("cfg reset", {8'h00, extIfConfig}, 16'h001B);
    check("timing reset", {8'h00, extIfTimingCtrl}, 16'h00FF);
    check("idle pins", {12'h000, ctrlOe, dataOe, addrHiOe, rdStrobeN}, 16'h0001);
    t_modes();
    t_timing();
    t_refuse();
    summarize();
  end
endmodule
bind emt_ext_mem_if emt_ext_mem_if_asserts chk (.core_clk, .sys_rst, .moveStart, .moveWide,
  .moveBusy, .moveDone, .extIfConfig, .extIfTimingCtrl, .addrHiOe, .addrLoOe, .dataOe,
  .rdStrobeN, .wrStrobeN, .aleOut, .ctrlOe);
`default_nettype wire

// File: rtl/emt_ext_mem_if.sv
// external memory interface sequencer: modes, phase timing, pin drive
`include "emt_params.svh"
`default_nettype none
module emt_ext_mem_if
  import emt_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        cfgWe,
  input  wire logic [2:0]  cfgMode,
  input  wire logic [1:0]  cfgAle,
  input  wire logic        cfgUpperPorts,
  input  wire logic        timingWe,
  input  wire logic [7:0]  timingCtrl,
  input  wire logic [7:0]  bankSelect,
  input  wire logic        moveStart,
  input  wire logic        moveWrite,
  input  wire logic        moveWide,
  input  wire logic [15:0] moveAddr,
  input  wire logic [7:0]  moveWData,
  input  wire logic [7:0]  memDataIn,
  output logic             moveBusy,
  output logic             moveDone,
  output logic [7:0]       moveRData,
  output logic [7:0]       extIfConfig,
  output logic [7:0]       extIfTimingCtrl,
  output logic [7:0]       addrHiOut,
  output logic             addrHiOe,
  output logic [7:0]       addrLoOut,
  output logic             addrLoOe,
  output logic [7:0]       dataOut,
  output logic             dataOe,
  output logic             rdStrobeN,
  output logic             wrStrobeN,
  output logic             aleOut,
  output logic             ctrlOe,
  output logic             usingUpperPorts
);
  import emt_pkg::*;

  emt_state_t state;
  emt_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [4:0] next_extIfConfig;
  logic [7:0] next_extIfTimingCtrl;
  logic [7:0] dataSync1;
  logic [7:0] dataSync2;
  logic [7:0] next_moveRData;
  logic       next_moveDone;
  logic       wr;
  logic       wide;
  logic       next_wr;
  logic       next_wide;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [7:0] wdata;
  logic [7:0] next_wdata;
  logic [7:0] next_addrHiOut;
  logic       next_addrHiOe;
  logic [7:0] next_addrLoOut;
  logic       next_addrLoOe;
  logic [7:0] next_dataOut;
  logic       next_dataOe;
  logic       next_rdStrobeN;
  logic       next_wrStrobeN;
  logic       next_aleOut;
  logic       next_ctrlOe;
  logic       nonMux;
  logic       bankSel;
  logic       hiDrive;
  logic [1:0] setupCnt;
  logic [3:0] strobeCnt;
  logic [1:0] holdCnt;
  logic [1:0] aleCnt;

  assign nonMux    = extIfConfig[`EMT_CFG_NONMUX];
  assign bankSel   = (extIfConfig[2:0] == `EMT_CFG_BANK) ||
                     (extIfConfig[2:0] == `EMT_CFG_BANK_NMX);
  assign hiDrive   = wide || bankSel;
  assign setupCnt  = extIfTimingCtrl[`EMT_SETUP_HI:`EMT_SETUP_LO];
  assign strobeCnt = extIfTimingCtrl[`EMT_STROBE_HI:`EMT_STROBE_LO];
  assign holdCnt   = extIfTimingCtrl[`EMT_HOLD_HI:`EMT_HOLD_LO];
  assign aleCnt    = extIfConfig[4:3];

  always_comb
  begin
    next_extIfConfig     = extIfConfig[4:0];
    next_extIfTimingCtrl = extIfTimingCtrl;
    if (cfgWe && state == EMT_IDLE)
    begin
      next_extIfConfig = {cfgAle, cfgMode};
    end
    if (timingWe && state == EMT_IDLE)
    begin
      next_extIfTimingCtrl = timingCtrl;
    end
  end

  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_wr        = wr;
    next_wide      = wide;
    next_addr      = addr;
    next_wdata     = wdata;
    next_moveDone  = 1'b0;
    next_moveRData = moveRData;
    next_addrHiOut = addrHiOut;
    next_addrHiOe  = addrHiOe;
    next_addrLoOut = addrLoOut;
    next_addrLoOe  = addrLoOe;
    next_dataOut   = dataOut;
    next_dataOe    = dataOe;
    next_rdStrobeN = 1'b1;
    next_wrStrobeN = 1'b1;
    next_aleOut    = 1'b0;
    next_ctrlOe    = ctrlOe;
    case (state)
      EMT_IDLE:
      begin
        if (moveStart)
        begin
          next_wr    = moveWrite;
          next_wide  = moveWide;
          next_addr  = moveWide ? moveAddr : {bankSelect, moveAddr[7:0]};
          next_wdata = moveWData;
          next_ctrlOe = 1'b1;
          next_cnt   = 5'(`EMT_FIXED_CYCLES - 3);
          next_state = EMT_FIN;
        end
      end
      EMT_FIN:
      begin
        // lead-in overhead cycles, then mux latch or setup
        if (cnt != 5'h0)
        begin
          next_cnt = cnt - 5'h1;
        end
        else
        begin
          next_addrHiOut = addr[15:8];
          next_addrHiOe  = hiDrive;
          next_addrLoOut = addr[7:0];
          next_addrLoOe  = 1'b1;
        end
        if (cnt != 5'h0)
        begin
          next_state = EMT_FIN;
        end
        else if (nonMux)
        begin
          next_cnt   = {3'b000, setupCnt};
          next_state = EMT_SETUP;
        end
        else
        begin
          next_aleOut = 1'b1;
          next_cnt    = {3'b000, aleCnt};
          next_state  = EMT_ALEHI;
        end
      end
      EMT_ALEHI:
      begin
        if (cnt == 5'h0)
        begin
          next_cnt   = {3'b000, aleCnt};
          next_state = EMT_ALELO;
        end
        else
        begin
          next_aleOut = 1'b1;
          next_cnt    = cnt - 5'h1;
        end
      end
      EMT_ALELO:
      begin
        next_addrLoOe = 1'b0;
        if (cnt == 5'h0)
        begin
          next_cnt   = {3'b000, setupCnt};
          next_state = EMT_SETUP;
        end
        else
        begin
          next_cnt = cnt - 5'h1;
        end
      end
      EMT_SETUP:
      begin
        if (!nonMux)
        begin
          next_addrLoOe = 1'b0;
        end
        if (wr)
        begin
          next_dataOut = wdata;
          next_dataOe  = 1'b1;
        end
        if (cnt == 5'h0)
        begin
          next_rdStrobeN = wr;
          next_wrStrobeN = !wr;
          next_cnt       = {1'b0, strobeCnt};
          next_state     = EMT_STROBE;
        end
        else
        begin
          next_cnt = cnt - 5'h1;
        end
      end
      EMT_STROBE:
      begin
        if (cnt == 5'h0)
        begin
          next_moveRData = dataSync2;
          next_cnt       = {3'b000, holdCnt};
          next_state     = EMT_HOLD;
        end
        else
        begin
          next_rdStrobeN = wr;
          next_wrStrobeN = !wr;
          next_cnt       = cnt - 5'h1;
        end
      end
      EMT_HOLD:
      begin
        if (cnt == 5'h0)
        begin
          next_dataOe   = 1'b0;
          next_addrHiOe = 1'b0;
          next_addrLoOe = 1'b0;
          next_ctrlOe   = 1'b0;
          next_moveDone = 1'b1;
          next_state    = EMT_IDLE;
        end
        else
        begin
          next_cnt = cnt - 5'h1;
        end
      end
      default:
      begin
        next_state = EMT_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state           <= EMT_IDLE;
      cnt             <= 5'h0;
      wr              <= 1'b0;
      wide            <= 1'b0;
      addr            <= 16'h0000;
      wdata           <= 8'h00;
      extIfConfig     <= {3'b000, `EMT_ALE_RESET, `EMT_CFG_RESET};
      extIfTimingCtrl <= `EMT_TC_RESET;
      dataSync1       <= 8'h00;
      dataSync2       <= 8'h00;
      moveRData       <= 8'h00;
      moveDone        <= 1'b0;
      moveBusy        <= 1'b0;
      addrHiOut       <= 8'h00;
      addrHiOe        <= 1'b0;
      addrLoOut       <= 8'h00;
      addrLoOe        <= 1'b0;
      dataOut         <= 8'h00;
      dataOe          <= 1'b0;
      rdStrobeN       <= 1'b1;
      wrStrobeN       <= 1'b1;
      aleOut          <= 1'b0;
      ctrlOe          <= 1'b0;
      usingUpperPorts <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      cnt             <= next_cnt;
      wr              <= next_wr;
      wide            <= next_wide;
      addr            <= next_addr;
      wdata           <= next_wdata;
      extIfConfig     <= {3'b000, next_extIfConfig};
      extIfTimingCtrl <= next_extIfTimingCtrl;
      dataSync1       <= memDataIn;
      dataSync2       <= dataSync1;
      moveRData       <= next_moveRData;
      moveDone        <= next_moveDone;
      moveBusy        <= (next_state != EMT_IDLE);
      addrHiOut       <= next_addrHiOut;
      addrHiOe        <= next_addrHiOe;
      addrLoOut       <= next_addrLoOut;
      addrLoOe        <= next_addrLoOe;
      dataOut         <= next_dataOut;
      dataOe          <= next_dataOe;
      rdStrobeN       <= next_rdStrobeN;
      wrStrobeN       <= next_wrStrobeN;
      aleOut          <= next_aleOut;
      ctrlOe          <= next_ctrlOe;
      usingUpperPorts <= (cfgWe && state == EMT_IDLE) ? cfgUpperPorts : usingUpperPorts;
    end
  end
endmodule
`default_nettype wire

// File: rtl/emt_params.svh
// timing field positions, reset values and cycle constants for the external memory interface
`ifndef EMT_PARAMS_SVH
`define EMT_PARAMS_SVH
`define EMT_TC_RESET      8'hFF
`define EMT_SETUP_HI      7
`define EMT_SETUP_LO      6
`define EMT_STROBE_HI     5
`define EMT_STROBE_LO     2
`define EMT_HOLD_HI       1
`define EMT_HOLD_LO       0
`define EMT_CFG_RESET     3'h3
`define EMT_CFG_NONMUX    2
`define EMT_CFG_BANK      3'h2
`define EMT_CFG_BANK_NMX  3'h6
`define EMT_ALE_RESET     2'h3
`define EMT_FIXED_CYCLES  4
`define EMT_ALE_EXTRA     2
`endif

// File: rtl/emt_pkg.sv
// types for the external memory interface sequencer
`default_nettype none
package emt_pkg;
  typedef enum logic [2:0] {
    EMT_IDLE   = 3'b000,
    EMT_ALEHI  = 3'b001,
    EMT_ALELO  = 3'b010,
    EMT_SETUP  = 3'b011,
    EMT_STROBE = 3'b100,
    EMT_HOLD   = 3'b101,
    EMT_FIN    = 3'b110
  } emt_state_t;
endpackage
`default_nettype wire
